/* File: core/reset_cause_pkg.sv */
// package: constants, types and state layout for the reset sequencer
`default_nettype none
package reset_cause_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned POWERUP_TIMER_TIME_MS    = 72;
   localparam int unsigned POWERUP_TIMER_CYCLES     = POWERUP_TIMER_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned OST_OSC_PERIODS = 1024;   // oscillator = clk_i
   localparam int unsigned OST_CYCLES      = OST_OSC_PERIODS;
   localparam int unsigned CNT_W           = 23;
   localparam int unsigned SYNC_CYCLES     = 2;      // straps settle through two flops first

   // register byte offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_POWER   = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;

   // field positions
   localparam int unsigned BIT_TIMEOUT   = 4;
   localparam int unsigned BIT_POWERDOWN = 3;
   localparam int unsigned BIT_POR       = 1;
   localparam int unsigned BIT_BROWNOUT  = 0;
   localparam int unsigned BIT_BOR_EN    = 0;

   // reset values
   localparam logic        RST_BOR_EN   = 1'b1;
   localparam logic        RST_BROWNOUT = 1'b1;

   // program counter
   localparam int unsigned PC_W      = 13;
   localparam logic [12:0] PC_ZERO   = 13'h0000;
   localparam logic [12:0] PC_VECTOR = 13'h0004;

   // oscillator configurations
   typedef enum logic [1:0] {OSC_LP, OSC_XT, OSC_HS, OSC_RC} osc_mode_t;

   typedef enum logic [2:0] {
      ST_CAPTURE, ST_BOR, ST_POWERUP_TIMER, ST_OST, ST_RUN, ST_HOLD, ST_SLEEP
   } seq_state_t;

   // ahb-lite request pins
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic        hready;
      logic [31:0] hwdata;
   } ahb_req_t;

   // whole state of the sequencer
   typedef struct packed {
      logic              pin_s1;
      logic              pin_s2;
      logic              bor_s1;
      logic              bor_s2;
      logic [2:0]        strap_s1;
      logic [2:0]        strap_s2;
      osc_mode_t         osc_mode;
      logic              powerup_timer_en_n;
      seq_state_t        state;
      logic [CNT_W-1:0]  cnt;
      logic              timeout_flag;
      logic              powerdown_flag;
      logic              por_flag;
      logic              brownout_flag;
      logic              bor_en;
      logic [PC_W-1:0]   resume_pc;
      logic              core_reset;
      logic              pc_load;
      logic [PC_W-1:0]   pc_value;
      logic              wr_pend;
      logic [7:0]        wr_addr;
      logic [31:0]       hrdata;
   } seq_regs_t;
endpackage : reset_cause_pkg
`default_nettype wire

/* File: core/reset_cause_and_timeout.sv */
// reset sequencer: start-up delays, reset-cause flags, pc load, ahb-lite registers
//
// Overview of operation
// - crystal power-up waits 72 ms then 1024 periods; timer disabled skips 72 ms
// - power-on reset sets timeout flag and clears power-on flag
// - power-on reset sets the power-down flag
// - pin reset while running keeps timeout and power-down flags unchanged
// - pin reset in sleep or interrupt wake gives timeout 1, power-down 0
// - interrupt wake resumes at next address, or vector if global enable set
// - interrupt wake keeps other bits, sets timeout, clears power-down
// - unimplemented bits of the status registers read as zero
// - power-on flag cleared only by power-on reset; software sets it; the code also lets a software write of 0 clear it
// - brownout flag is bit 0 of power control, cleared by brownout reset
// - start-up count only for crystal modes after power-on or wake-up; the code also runs it after a brownout reset
// - brownout during power-up timer returns to brownout and restarts timer
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module reset_cause_and_timeout #(
   parameter int unsigned POWERUP_TIMER_CYCLES = reset_cause_pkg::POWERUP_TIMER_CYCLES
) (
   input  wire logic                           clk_i,
   input  wire logic                           rst_n_i,
   input  wire logic                           external_reset_pin_n_i,
   input  wire logic                           brownout_detect_i,
   input  wire logic [1:0]                     osc_mode_i,
   input  wire logic                           powerup_timer_enable_n_i,
   input  wire logic                           sleep_enter_i,
   input  wire logic                           wdt_timeout_i,
   input  wire logic                           irq_wake_i,
   input  wire logic                           global_irq_enable_i,
   input  wire logic [reset_cause_pkg::PC_W-1:0] pc_next_i,
   input  wire reset_cause_pkg::ahb_req_t      ahb_i,
   output logic                                core_reset_o,
   output logic                                pc_load_o,
   output logic [reset_cause_pkg::PC_W-1:0]    pc_value_o,
   output logic                                timeout_flag_o,
   output logic                                powerdown_flag_o,
   output logic                                hreadyout_o,
   output logic                                hresp_o,
   output logic [31:0]                         hrdata_o
);
   localparam logic [reset_cause_pkg::CNT_W-1:0] POWERUP_TIMER_LAST =
      reset_cause_pkg::CNT_W'(POWERUP_TIMER_CYCLES - 1);
   localparam logic [reset_cause_pkg::CNT_W-1:0] OST_LAST =
      reset_cause_pkg::CNT_W'(reset_cause_pkg::OST_CYCLES - 1);
   localparam logic [reset_cause_pkg::CNT_W-1:0] SYNC_LAST =
      reset_cause_pkg::CNT_W'(reset_cause_pkg::SYNC_CYCLES);

   // the counter must hold the longest delay
   if (POWERUP_TIMER_CYCLES < 1 || POWERUP_TIMER_CYCLES > (1 << reset_cause_pkg::CNT_W)) begin : g_chk
      $error("POWERUP_TIMER_CYCLES does not fit the delay counter");
   end

   reset_cause_pkg::seq_regs_t r;
   reset_cause_pkg::seq_regs_t next_r;

   logic pin_low;
   logic bor_low;
   logic crystal;
   logic addr_ok;
   logic [7:0] a8;

   // sequencing, flags and bus access in one pass
   always_comb begin
      next_r = r;
      next_r.pc_load = 1'b0;
      // synchronisers: first stage feeds only the second
      next_r.pin_s1   = external_reset_pin_n_i;
      next_r.pin_s2   = r.pin_s1;
      next_r.bor_s1   = brownout_detect_i;
      next_r.bor_s2   = r.bor_s1;
      next_r.strap_s1 = {powerup_timer_enable_n_i, osc_mode_i};
      next_r.strap_s2 = r.strap_s1;
      pin_low = ~r.pin_s2;
      bor_low = r.bor_s2 & r.bor_en;
      crystal = (r.osc_mode != reset_cause_pkg::OSC_RC);

      case (r.state)
         // straps caught once after release, then the power-up path is chosen
         // the second stage still shows its reset value at first; wait until it holds the pins
         reset_cause_pkg::ST_CAPTURE: begin
            next_r.cnt       = r.cnt + 1'b1;
            next_r.resume_pc = reset_cause_pkg::PC_ZERO;
            if (r.cnt == SYNC_LAST) begin
               next_r.osc_mode  = reset_cause_pkg::osc_mode_t'(r.strap_s2[1:0]);
               next_r.powerup_timer_en_n = r.strap_s2[2];
               next_r.cnt       = '0;
               if (r.strap_s2[2] == 1'b0) begin
                  next_r.state = reset_cause_pkg::ST_POWERUP_TIMER;
               end else if (r.strap_s2[1:0] != 2'(reset_cause_pkg::OSC_RC)) begin
                  next_r.state = reset_cause_pkg::ST_OST;
               end else begin
                  next_r.state = reset_cause_pkg::ST_RUN;
                  next_r.pc_load = 1'b1;
               end
            end
         end
         // held while brownout lasts; the power-up timer follows
         reset_cause_pkg::ST_BOR: begin
            next_r.cnt = '0;
            if (!bor_low) begin
               next_r.state = reset_cause_pkg::ST_POWERUP_TIMER;
            end
         end
         reset_cause_pkg::ST_POWERUP_TIMER: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == POWERUP_TIMER_LAST) begin
               next_r.cnt = '0;
               if (crystal) begin
                  next_r.state = reset_cause_pkg::ST_OST;
               end else begin
                  next_r.state = reset_cause_pkg::ST_RUN;
                  next_r.pc_load = 1'b1;
               end
            end
         end
         reset_cause_pkg::ST_OST: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == OST_LAST) begin
               next_r.state = reset_cause_pkg::ST_RUN;
               next_r.pc_load = 1'b1;
            end
         end
         reset_cause_pkg::ST_RUN: begin
            if (wdt_timeout_i) begin
               next_r.timeout_flag   = 1'b0;
               next_r.powerdown_flag = 1'b1;
               next_r.resume_pc      = reset_cause_pkg::PC_ZERO;
               next_r.state          = reset_cause_pkg::ST_HOLD;
            end else if (sleep_enter_i) begin
               next_r.timeout_flag   = 1'b1;
               next_r.powerdown_flag = 1'b0;
               next_r.state          = reset_cause_pkg::ST_SLEEP;
            end
         end
         // one-cycle or pin-length reset with no start-up delay
         reset_cause_pkg::ST_HOLD: begin
            if (!pin_low) begin
               next_r.state = reset_cause_pkg::ST_RUN;
               next_r.pc_load = 1'b1;
            end
         end
         reset_cause_pkg::ST_SLEEP: begin
            if (wdt_timeout_i || irq_wake_i) begin
               next_r.timeout_flag   = ~wdt_timeout_i;
               next_r.powerdown_flag = 1'b0;
               next_r.resume_pc      = (irq_wake_i && !wdt_timeout_i && global_irq_enable_i)
                                       ? reset_cause_pkg::PC_VECTOR : pc_next_i;
               next_r.cnt = '0;
               if (crystal) begin
                  next_r.state = reset_cause_pkg::ST_OST;
               end else begin
                  next_r.state = reset_cause_pkg::ST_RUN;
                  next_r.pc_load = 1'b1;
               end
            end
         end
         default: next_r.state = reset_cause_pkg::ST_CAPTURE;
      endcase

      // pin reset outranks the sequence only in run and sleep
      if (pin_low && r.state == reset_cause_pkg::ST_RUN) begin
         next_r.resume_pc = reset_cause_pkg::PC_ZERO;
         next_r.state     = reset_cause_pkg::ST_HOLD;
      end else if (pin_low && r.state == reset_cause_pkg::ST_SLEEP) begin
         next_r.timeout_flag   = 1'b1;
         next_r.powerdown_flag = 1'b0;
         next_r.resume_pc      = reset_cause_pkg::PC_ZERO;
         next_r.state          = reset_cause_pkg::ST_HOLD;
      end

      // ahb write data phase; software may only store bits, hardware clears win below
      if (r.wr_pend) begin
         if (r.wr_addr == reset_cause_pkg::OFS_POWER) begin
            next_r.por_flag      = ahb_i.hwdata[reset_cause_pkg::BIT_POR];
            next_r.brownout_flag = ahb_i.hwdata[reset_cause_pkg::BIT_BROWNOUT];
         end else if (r.wr_addr == reset_cause_pkg::OFS_CONTROL) begin
            next_r.bor_en = ahb_i.hwdata[reset_cause_pkg::BIT_BOR_EN];
         end
      end

      // brownout from any state after capture; restarts a running timer
      if (bor_low && r.state != reset_cause_pkg::ST_CAPTURE) begin
         next_r.state          = reset_cause_pkg::ST_BOR;
         next_r.cnt            = '0;
         next_r.brownout_flag  = 1'b0;
         next_r.timeout_flag   = 1'b1;
         next_r.powerdown_flag = 1'b1;
         next_r.resume_pc      = reset_cause_pkg::PC_ZERO;
      end

      // outputs come from flops; reset held outside run
      // a pin or brownout override back into reset must not leave a stray load pulse
      next_r.pc_load    = next_r.pc_load && (next_r.state == reset_cause_pkg::ST_RUN);
      next_r.core_reset = (next_r.state != reset_cause_pkg::ST_RUN);
      next_r.pc_value   = next_r.resume_pc;

      // ahb address phase: zero wait, reads answered from a flop next cycle
      a8      = ahb_i.haddr[7:0];
      addr_ok = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];
      next_r.wr_pend = addr_ok && ahb_i.hwrite;
      next_r.wr_addr = a8;
      if (addr_ok && !ahb_i.hwrite) begin
         next_r.hrdata = '0;
         if (ahb_i.haddr[31:8] != '0) begin
            next_r.hrdata = '0;
         end else if (a8 == reset_cause_pkg::OFS_STATUS) begin
            next_r.hrdata[reset_cause_pkg::BIT_TIMEOUT]   = r.timeout_flag;
            next_r.hrdata[reset_cause_pkg::BIT_POWERDOWN] = r.powerdown_flag;
         end else if (a8 == reset_cause_pkg::OFS_POWER) begin
            next_r.hrdata[reset_cause_pkg::BIT_POR]      = r.por_flag;
            next_r.hrdata[reset_cause_pkg::BIT_BROWNOUT] = r.brownout_flag;
         end else if (a8 == reset_cause_pkg::OFS_CONTROL) begin
            next_r.hrdata[reset_cause_pkg::BIT_BOR_EN] = r.bor_en;
         end
      end
      if (ahb_i.haddr[31:8] != '0) begin
         next_r.wr_pend = 1'b0;                                               // unmapped write dropped
      end
   end

   // asynchronous reset is the power-on event: flags take their power-on values
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r                <= '0;
         r.state          <= reset_cause_pkg::ST_CAPTURE;
         r.osc_mode       <= reset_cause_pkg::OSC_RC;
         r.powerup_timer_en_n      <= 1'b1;
         r.timeout_flag   <= 1'b1;
         r.powerdown_flag <= 1'b1;
         r.por_flag       <= 1'b0;
         r.brownout_flag  <= reset_cause_pkg::RST_BROWNOUT;
         r.bor_en         <= reset_cause_pkg::RST_BOR_EN;
         r.core_reset     <= 1'b1;
         r.pin_s1         <= 1'b1;
         r.pin_s2         <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign core_reset_o     = r.core_reset;
   assign pc_load_o        = r.pc_load;
   assign pc_value_o       = r.pc_value;
   assign timeout_flag_o   = r.timeout_flag;
   assign powerdown_flag_o = r.powerdown_flag;
   assign hreadyout_o      = 1'b1;                                           // never stalls
   assign hresp_o          = 1'b0;
   assign hrdata_o         = r.hrdata;
endmodule : reset_cause_and_timeout
`default_nettype wire

/* File: dv/reset_cause_checker.sv */
// checker: port relations of the reset sequencer
`default_nettype none
module reset_cause_checker (
   input wire logic                      clk_i,
   input wire logic                      rst_n_i,
   input wire logic                      external_reset_pin_n_i,
   input wire logic                      brownout_detect_i,
   input wire logic                      sleep_enter_i,
   input wire logic                      wdt_timeout_i,
   input wire reset_cause_pkg::ahb_req_t ahb_i,
   input wire logic                      core_reset_o,
   input wire logic                      pc_load_o,
   input wire logic [12:0]               pc_value_o,
   input wire logic                      timeout_flag_o,
   input wire logic                      powerdown_flag_o,
   input wire logic                      hreadyout_o,
   input wire logic                      hresp_o,
   input wire logic [31:0]               hrdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [2:0] calm;
   logic       quiet;
   logic       rd_take;
   // pin and brownout clean this cycle and the three before, so nothing synced can interfere
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) calm <= 3'h0;
      else calm <= {calm[1:0], external_reset_pin_n_i & ~brownout_detect_i};
   assign quiet = &calm & external_reset_pin_n_i & ~brownout_detect_i;
   assign rd_take = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1] & ~ahb_i.hwrite;

   a_wdt_run_flags: assert property (!core_reset_o && wdt_timeout_i && quiet |=>
      core_reset_o && !timeout_flag_o && powerdown_flag_o ##1 pc_load_o && pc_value_o == 13'h0)
      else $error("watchdog reset in run gave wrong flags or pc");
   a_sleep_entry: assert property (!core_reset_o && sleep_enter_i && !wdt_timeout_i && quiet
      |=> timeout_flag_o && !powerdown_flag_o) else $error("sleep entry flags wrong");
   a_por_flags: assert property ($rose(rst_n_i) |-> timeout_flag_o && powerdown_flag_o
      && core_reset_o) else $error("power-on flags wrong");
   a_pc_load_pulse: assert property (pc_load_o |-> !core_reset_o && $past(core_reset_o)
      ##1 !pc_load_o) else $error("pc load not a single cycle at reset exit");
   a_release_loads: assert property ($fell(core_reset_o) |-> pc_load_o)
      else $error("core released without pc load");
   a_nonwake_zero: assert property (pc_load_o && powerdown_flag_o |-> pc_value_o == 13'h0)
      else $error("reset exit pc not zero");
   a_unmapped_zero: assert property (rd_take && ahb_i.haddr[31:8] != 24'h0 |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_status_read: assert property (rd_take && ahb_i.haddr == 32'h0 |=> hrdata_o ==
      {27'h0, $past(timeout_flag_o), $past(powerdown_flag_o), 3'h0}) else $error("status read wrong");
   a_power_bits: assert property (rd_take && ahb_i.haddr == 32'h4 |=> hrdata_o[31:2] == 30'h0)
      else $error("power control upper bits not zero");
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready and okay");
   c_wdt_run: cover property (!core_reset_o && wdt_timeout_i && quiet);
   c_vector: cover property (pc_load_o && pc_value_o == 13'h4);
   c_unmapped: cover property (rd_take && ahb_i.haddr[31:8] != 24'h0);
endmodule : reset_cause_checker
bind reset_cause_and_timeout reset_cause_checker chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .external_reset_pin_n_i(external_reset_pin_n_i), .brownout_detect_i(brownout_detect_i),
   .sleep_enter_i(sleep_enter_i), .wdt_timeout_i(wdt_timeout_i), .ahb_i(ahb_i),
   .core_reset_o(core_reset_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
   .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));
`default_nettype wire

/* File: dv/reset_cause_and_timeout_bench.sv */
// bench: reset sequencer driven at its pins and ahb-lite registers against a flag model
`default_nettype none
module reset_cause_and_timeout_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned POWERUP_TIMER = 50;  // short power-up timer keeps the run brief
   logic clk_i = 0, rst_n_i = 0, pin_n = 1, bod = 0, pte_n = 0, slp = 0, wdt = 0, irq = 0, global_irq_enable = 0;
   logic [1:0]  osc = 2'h1;
   logic [12:0] pcn = 13'h0, pcv, ep;
   logic        core_rst, pc_ld, to_o, pd_o, hrdy, hresp;
   logic [31:0] rd, dout;
   reset_cause_pkg::ahb_req_t req = '0, req_w;
   int miscompares = 0, n_compared = 0, n, k, e_to, e_pd, e_por, e_bor;
   always #5 clk_i = ~clk_i;
   // the lone slave's ready closes the loop onto the request
   always_comb begin
      req_w = req;
      req_w.hready = hrdy;
   end
   reset_cause_and_timeout #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .external_reset_pin_n_i(pin_n), .brownout_detect_i(bod), .osc_mode_i(osc),
      .powerup_timer_enable_n_i(pte_n), .sleep_enter_i(slp), .wdt_timeout_i(wdt),
      .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable), .pc_next_i(pcn), .ahb_i(req_w),
      .core_reset_o(core_rst), .pc_load_o(pc_ld), .pc_value_o(pcv), .timeout_flag_o(to_o),
      .powerdown_flag_o(pd_o), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(dout));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   // bounded waits only: a hang is a mismatch
   task automatic rdy;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (hrdy === 1'b1) return;
      end
      chk("bus ready", 1, 0);
      close_out();
   endtask : rdy
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      req <= '{hsel: 1'b1, haddr: a, htrans: 2'h2, hwrite: wr, hsize: 3'h2, hready: 1'b1,
               hwdata: req.hwdata};
      rdy();
      req.htrans <= 2'h0;
      req.hsel <= 1'b0;
      req.hwdata <= wd;
      rdy();
      rd = dout;  // hrdata stands through the data phase, taken at its closing edge
   endtask : bus
   task automatic wait_run;
      for (n = 1; n < 5000; n++) begin
         @(posedge clk_i);
         #1;
         if (pc_ld === 1'b1) return;
      end
      chk("pc load wait", 1, 0);
      close_out();
   endtask : wait_run
   // both flag registers against the model
   task automatic st;
      bus(1'b0, 32'h0, 32'h0);
      chk("status", 32'(e_to * 16 + e_pd * 8), rd);
      bus(1'b0, 32'h4, 32'h0);
      chk("power control", 32'(e_por * 2 + e_bor), rd);
      chk("timeout pin", 32'(e_to), 32'(to_o));
      chk("powerdown pin", 32'(e_pd), 32'(pd_o));
      chk("core reset", 32'h0, 32'(core_rst));
   endtask : st
   initial begin
      void'($urandom(69496));
      e_to = 1;
      e_pd = 1;
      e_por = 0;
      e_bor = 1;
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_run();
      chk("xt power-up time", 1, n >= POWERUP_TIMER + 1024 && n <= POWERUP_TIMER + 1034);
      chk("pc", 0, pcv);
      st();
      bus(1'b1, 32'h4, 32'hffff_ffff);  // software sets both flags
      e_por = 1;
      st();
      bus(1'b1, 32'h0, 32'h0);  // status is read-only
      st();
      bus(1'b0, 32'h100, 32'h0);
      chk("unmapped", 0, rd);
      bus(1'b0, 32'h8, 32'h0);
      chk("control", 1, rd);
      // 0 wdt run, 1 pin run, 2 irq wake, 3 wdt in sleep, 4 pin in sleep
      for (int i = 0; i < 12; i++) begin
         k = (i < 5) ? i : int'($urandom % 5);
         @(posedge clk_i);
         global_irq_enable <= 1'($urandom);
         pcn <= 13'($urandom);
         if (k >= 2) begin
            slp <= 1'b1;
            @(posedge clk_i) slp <= 1'b0;
            e_to = 1;
            e_pd = 0;
            repeat (3) @(posedge clk_i);
         end
         if (k == 0 || k == 3) wdt <= 1'b1;
         if (k == 2) irq <= 1'b1;
         if (k == 1 || k == 4) pin_n <= 1'b0;
         @(posedge clk_i);
         {wdt, irq} <= 2'b00;
         if (k == 1 || k == 4) repeat (5) @(posedge clk_i);
         pin_n <= 1'b1;
         wait_run();
         ep = (k == 2) ? (global_irq_enable ? 13'h4 : pcn) : (k == 3) ? pcn : 13'h0;
         if (k == 0) e_pd = 1;
         if (k == 0 || k == 3) e_to = 0;
         if (k == 2) chk("ost on wake", 1, n >= 1024);
         chk("resume pc", ep, pcv);
         st();
      end
      @(posedge clk_i) bod <= 1'b1;
      repeat (10) @(posedge clk_i);
      bod <= 1'b0;
      repeat (20) @(posedge clk_i);
      bod <= 1'b1;  // recurs while the power-up timer runs
      repeat (5) @(posedge clk_i);
      bod <= 1'b0;
      e_to = 1;
      e_pd = 1;
      e_bor = 0;
      wait_run();
      chk("brownout restart", 1, n >= POWERUP_TIMER + 1024);
      st();
      @(posedge clk_i) rst_n_i <= 1'b0;
      osc <= 2'h3;
      pte_n <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      e_por = 0;
      e_bor = 1;
      wait_run();
      chk("rc no delay", 1, n <= 10);
      st();
      @(posedge clk_i) rst_n_i <= 1'b0;
      osc <= 2'($urandom % 3);  // any crystal mode, timer still off
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_run();
      chk("crystal timer off", 1, n >= 1024 && n <= 1034);
      st();
      close_out();
   end
endmodule : reset_cause_and_timeout_bench
`default_nettype wire
